// *** src/lbc_pkg.sv ***
// shared types and constants of the loadable binary counter
package lbc_pkg;

  // default number of counter bits
  localparam int LBC_DEF_WIDTH = 8;

  // value of every count bit after asynchronous clear
  localparam logic LBC_RESET_BIT = 1'b0;

  // one step of the count, in either direction
  localparam int LBC_STEP = 1;

  // counting direction of the built variant
  typedef enum logic
  {
    LBC_DOWN,
    LBC_UP
  } lbc_dir_t;

  // controls from the surrounding logic, sampled at the rising edge
  typedef struct packed
  {
    logic load;
    logic count_en;
  } lbc_ctrl_t;

  // what the counter shows to the surrounding logic
  typedef struct packed
  {
    logic term;
    logic clk_en_seen;
  } lbc_flag_t;

endpackage

// *** src/lbc_counter.sv ***
// loadable binary counter, down or up variant, with terminal count
`timescale 1ns/1ps

// Behaviour
// - changes only on rising clock, except reset
// - down variant subtracts one when counting
// - up variant adds one when counting
// - load plus count enable takes data
// - count enable low holds the value
// - low reset clears to zero, no clock
// - down variant terminal flag at zero
// - up variant terminal flag at ones
// - width parameter sizes count and data
module lbc_counter
#(
  parameter int WIDTH = lbc_pkg::LBC_DEF_WIDTH,
  parameter lbc_pkg::lbc_dir_t DIRECTION = lbc_pkg::LBC_DOWN
)
(
  // clock, reset and clock enable
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic clk_en_in,
  // controls and parallel data
  input wire lbc_pkg::lbc_ctrl_t ctrl_in,
  input wire logic [WIDTH-1:0] data_in,
  // count and terminal flag
  output logic [WIDTH-1:0] counter_output_out,
  output logic term_out
);
  import lbc_pkg::*;

  typedef struct packed
  {
    logic [WIDTH-1:0] count;
    logic term;
  } lbc_state_t;

  localparam logic [WIDTH-1:0] RESET_COUNT = {WIDTH{LBC_RESET_BIT}};
  localparam logic [WIDTH-1:0] STEP = WIDTH'(LBC_STEP);
  localparam logic [WIDTH-1:0] ALL_ONES = {WIDTH{1'b1}};
  // terminal flag that matches the cleared count
  localparam logic RESET_TERM = (DIRECTION == LBC_DOWN) ?
                                (RESET_COUNT == '0) :
                                (RESET_COUNT == ALL_ONES);
  localparam lbc_state_t RESET_STATE = '{count: RESET_COUNT,
                                         term: RESET_TERM};

  lbc_state_t state;
  lbc_state_t next_state;
  logic [WIDTH-1:0] next_count;

  always_comb
  begin
    next_state = state;
    next_count = state.count;
    if (ctrl_in.count_en)
    begin
      if (ctrl_in.load)
      begin
        next_count = data_in;
      end
      else if (DIRECTION == LBC_DOWN)
      begin
        next_count = state.count - STEP;
      end
      else
      begin
        next_count = state.count + STEP;
      end
    end
    next_state.count = next_count;
    if (DIRECTION == LBC_DOWN)
    begin
      next_state.term = (next_count == '0);
    end
    else
    begin
      next_state.term = (next_count == ALL_ONES);
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state <= RESET_STATE;
    end
    else if (clk_en_in)
    begin
      state <= next_state;
    end
  end

  assign counter_output_out = state.count;
  assign term_out = state.term;

  // checks on the registered outputs

  chk_hold_when_off: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (clk_en_in && !ctrl_in.count_en) |=>
      $stable(counter_output_out) && $stable(term_out))
  else $error("count moved while count enable was low");

  chk_load_takes_data: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (clk_en_in && ctrl_in.count_en && ctrl_in.load) |=>
      (counter_output_out == $past(data_in)))
  else $error("load did not take the parallel data");

  chk_edge_only: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    $changed(counter_output_out) |->
      $past(clk_en_in && ctrl_in.count_en))
  else $error("count changed without an enabled edge");

  chk_clear_zero: assert property (
    @(posedge ref_clk_in)
    !nrst_in |-> (counter_output_out == '0) && (term_out == RESET_TERM))
  else $error("count not cleared while reset low");

  chk_term_tracks_count: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    $changed(term_out) |-> $changed(counter_output_out))
  else $error("terminal flag changed without a count change");

  chk_freeze_no_clk_en: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    !clk_en_in |=> $stable(counter_output_out) && $stable(term_out))
  else $error("count moved while clock enable was low");

  chk_stray_load_held: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (clk_en_in && ctrl_in.load && !ctrl_in.count_en) |=>
      $stable(counter_output_out) && $stable(term_out))
  else $error("load without count enable moved the count");

  generate
    if (DIRECTION == LBC_DOWN)
    begin : g_down_chk
      chk_down_step: assert property (
        @(posedge ref_clk_in) disable iff (!nrst_in)
        (clk_en_in && ctrl_in.count_en && !ctrl_in.load) |=>
          (counter_output_out == WIDTH'($past(counter_output_out) - STEP)))
      else $error("down count did not subtract one");

      chk_down_wrap: assert property (
        @(posedge ref_clk_in) disable iff (!nrst_in)
        (clk_en_in && ctrl_in.count_en && !ctrl_in.load &&
         counter_output_out == '0) |=> (counter_output_out == ALL_ONES))
      else $error("down count did not wrap to all ones");

      chk_term_zero: assert property (
        @(posedge ref_clk_in) disable iff (!nrst_in)
        term_out == (counter_output_out == '0))
      else $error("terminal flag does not match zero count");

      chk_down_load_term: assert property (
        @(posedge ref_clk_in) disable iff (!nrst_in)
        (clk_en_in && ctrl_in.count_en && ctrl_in.load) |=>
          (term_out == ($past(data_in) == '0)))
      else $error("flag after load does not match zero data");

      chk_down_term_clears: assert property (
        @(posedge ref_clk_in) disable iff (!nrst_in)
        (term_out && clk_en_in && ctrl_in.count_en && !ctrl_in.load) |=>
          !term_out)
      else $error("flag stayed high after counting below zero");
    end
    else
    begin : g_up_chk
      chk_up_step: assert property (
        @(posedge ref_clk_in) disable iff (!nrst_in)
        (clk_en_in && ctrl_in.count_en && !ctrl_in.load) |=>
          (counter_output_out == WIDTH'($past(counter_output_out) + STEP)))
      else $error("up count did not add one");

      chk_up_wrap: assert property (
        @(posedge ref_clk_in) disable iff (!nrst_in)
        (clk_en_in && ctrl_in.count_en && !ctrl_in.load &&
         counter_output_out == ALL_ONES) |=> (counter_output_out == '0))
      else $error("up count did not wrap to zero");

      chk_term_ones: assert property (
        @(posedge ref_clk_in) disable iff (!nrst_in)
        term_out == (counter_output_out == ALL_ONES))
      else $error("terminal flag does not match all-ones count");

      chk_up_load_term: assert property (
        @(posedge ref_clk_in) disable iff (!nrst_in)
        (clk_en_in && ctrl_in.count_en && ctrl_in.load) |=>
          (term_out == ($past(data_in) == ALL_ONES)))
      else $error("flag after load does not match all-ones data");

      chk_up_term_clears: assert property (
        @(posedge ref_clk_in) disable iff (!nrst_in)
        (term_out && clk_en_in && ctrl_in.count_en && !ctrl_in.load) |=>
          !term_out)
      else $error("flag stayed high after counting past all ones");
    end
  endgenerate

  chk_width_match: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (clk_en_in && ctrl_in.count_en && ctrl_in.load && data_in == ALL_ONES)
      |=> (counter_output_out == ALL_ONES))
  else $error("load lost bits of the parallel data");

endmodule

// *** bench/lbc_ctl_model.sv ***
// model of the surrounding logic that issues load and count requests
`timescale 1ns/1ps
module lbc_ctl_model
(
  // request from the bench: 10 load, 01 count, 11 stray load, 00 idle
  input wire logic [1:0] op_in,
  input wire logic [7:0] val_in,
  // controls and data to the counter
  output lbc_pkg::lbc_ctrl_t ctrl_out,
  output logic [7:0] data_out
);
  import lbc_pkg::*;
  assign ctrl_out = '{load: op_in[1], count_en: op_in[1] ^ op_in[0]};
  // data is only meaningful on a load, so show garbage unless op_in[1] is set
  assign data_out = op_in[1] ? val_in : ~val_in;
endmodule

// *** bench/tb_lbc_counter.sv ***
// self-checking bench running the down and up counters side by side
`timescale 1ns/1ps
module tb_lbc_counter;
  import lbc_pkg::*;
  logic ref_clk_in = 1'b0;
  logic nrst_in = 1'b1;
  logic clk_en_in = 1'b1;
  logic [1:0] op = 2'h0;
  logic [7:0] val = 8'h00;
  lbc_ctrl_t ctrl;
  logic [7:0] data, cd, cu;
  logic td, tu;
  int num_errors = 0;
  int num_checks = 0;
  always #5 ref_clk_in = ~ref_clk_in;
  lbc_ctl_model drv (.op_in(op), .val_in(val), .ctrl_out(ctrl),
    .data_out(data));
  lbc_counter #(.WIDTH(8), .DIRECTION(LBC_DOWN)) uut (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .clk_en_in(clk_en_in),
    .ctrl_in(ctrl), .data_in(data), .counter_output_out(cd),
    .term_out(td));
  lbc_counter #(.WIDTH(8), .DIRECTION(LBC_UP)) uut_up (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .clk_en_in(clk_en_in),
    .ctrl_in(ctrl), .data_in(data), .counter_output_out(cu),
    .term_out(tu));
  task automatic chk(input string nm, input logic [8:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic both(input logic [7:0] d, u);
    chk("down", {td, cd}, {d == 8'h00, d});
    chk("up", {tu, cu}, {u == 8'hFF, u});
  endtask
  task automatic step(input logic [1:0] o, input logic [7:0] v, d, u);
    @(negedge ref_clk_in);
    op = o;
    val = v;
    @(posedge ref_clk_in);
    #1;
    both(d, u);
  endtask
  task automatic t_down_wrap();
    step(2'b10, 8'h02, 8'h02, 8'h02);
    step(2'b01, 8'h00, 8'h01, 8'h03);
    step(2'b01, 8'h00, 8'h00, 8'h04);
    step(2'b01, 8'h00, 8'hFF, 8'h05);
    $display("done down_wrap");
  endtask
  task automatic t_up_wrap();
    step(2'b10, 8'hFE, 8'hFE, 8'hFE);
    step(2'b01, 8'h00, 8'hFD, 8'hFF);
    step(2'b01, 8'h00, 8'hFC, 8'h00);
    $display("done up_wrap");
  endtask
  task automatic t_hold();
    step(2'b11, 8'h55, 8'hFC, 8'h00);
    step(2'b00, 8'h00, 8'hFC, 8'h00);
    @(negedge ref_clk_in);
    clk_en_in = 1'b0;
    step(2'b10, 8'h33, 8'hFC, 8'h00);
    step(2'b01, 8'h00, 8'hFC, 8'h00);
    @(negedge ref_clk_in);
    clk_en_in = 1'b1;
    op = 2'b00;
    $display("done hold");
  endtask
  task automatic t_full_load();
    step(2'b10, 8'hFF, 8'hFF, 8'hFF);
    step(2'b01, 8'h00, 8'hFE, 8'h00);
    $display("done full_load");
  endtask
  task automatic t_reset();
    step(2'b10, 8'h80, 8'h80, 8'h80);
    @(negedge ref_clk_in);
    op = 2'b01;
    #2;
    nrst_in = 1'b0;
    #1;
    both(8'h00, 8'h00);
    @(posedge ref_clk_in);
    #1;
    both(8'h00, 8'h00);
    @(negedge ref_clk_in);
    op = 2'b00;
    nrst_in = 1'b1;
    step(2'b01, 8'h00, 8'hFF, 8'h01);
    $display("done reset");
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #1;
    nrst_in = 1'b0;
    repeat (20) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    nrst_in = 1'b1;
    t_down_wrap();
    t_up_wrap();
    t_hold();
    t_full_load();
    t_reset();
    close_out();
  end
endmodule
